// file: hdl/pat_translator.sv
// Purpose: paged address translator with 32-entry cache and table walk
// Assumes: cpu and memory ports are logic on the pclk domain
// Notes:   memory request may stay high back to back with new content
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pat_translator (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb register port
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [pat_pkg::DATA_W-1:0] pwdata,
  output logic [pat_pkg::DATA_W-1:0]      prdata,
  output logic                            pready,
  output logic                            pslverr,
  // cpu translation port
  input  wire logic                       cpu_req,
  input  wire pat_pkg::pat_cpu_req_t      cpu_in,
  output logic                            cpu_done,
  output logic                            cpu_abort,
  output logic [pat_pkg::ADDR_W-1:0]      cpu_paddr,
  // memory port for the table walk
  output logic                            mem_req,
  output pat_pkg::pat_mem_req_t           mem_out,
  input  wire logic                       mem_ack,
  input  wire logic [pat_pkg::DATA_W-1:0] mem_rdata
);
  import pat_pkg::*;

  // =========================================================
  // declarations
  pat_state_t        st_q;
  pat_cpu_req_t      req_q;
  logic              space_q;
  logic [DATA_W-1:0] root_q;
  logic [DATA_W-1:0] ent_q;
  logic              mem_req_q;
  pat_mem_req_t      mem_q;
  logic              done_q;
  logic              abort_q;
  logic [ADDR_W-1:0] paddr_q;

  logic [ADDR_W-1:0] sys_root;
  logic [ADDR_W-1:0] usr_root;
  logic              split;
  logic              inv_page_en;
  logic [PAGE_W-1:0] inv_page;
  logic              inv_sys;
  logic              inv_usr;

  logic              take;
  logic              space;
  logic [TAG_W-1:0]  lk_tag;
  logic [CACHE_N-1:0] hit_vec;
  logic [CACHE_N-1:0] val_vec;
  logic [CACHE_N-1:0] mod_vec;
  logic [PAGE_W-1:0] frame_arr [CACHE_N];
  logic [AGE_W-1:0]  age_arr [CACHE_N];
  logic              hit;
  logic [IDX_W-1:0]  hit_idx;
  logic [PAGE_W-1:0] hit_frame;
  logic              hit_mod;
  logic              use_hit;
  logic [IDX_W-1:0]  vic_idx;
  logic              reuse_q;
  logic [IDX_W-1:0]  reuse_idx_q;
  logic              fill_en;
  logic [TAG_W-1:0]  fill_tag;
  logic              touch_en;
  logic [IDX_W-1:0]  touch_idx;
  logic [AGE_W-1:0]  touch_age;
  logic [ADDR_W-1:0] root_addr;
  logic [ADDR_W-1:0] ptr_addr;
  logic              need_ptr_wb;
  logic [DATA_W-1:0] ptr_new;

  // =========================================================
  // register file
  pat_regs u_regs (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .fault_set             (st_q == S_FAULT),
    .fault_addr            (req_q.laddr),
    .busy                  (st_q != S_IDLE),
    .system_table_root_reg (sys_root),
    .user_table_root_reg   (usr_root),
    .split_space_bit       (split),
    .inv_page_en           (inv_page_en),
    .inv_page              (inv_page),
    .inv_sys               (inv_sys),
    .inv_usr               (inv_usr)
  );

  // =========================================================
  // lookup
  // a request is taken only while idle with no answer showing
  assign take = cpu_req && st_q == S_IDLE && !done_q && !abort_q;

  assign space = cpu_in.user && !split;

  assign lk_tag = {space, cpu_in.laddr[ADDR_W-1:OFS_W]};

  // encode hit and pull out the matching frame
  always_comb begin
    hit       = 1'b0;
    hit_idx   = '0;
    hit_frame = '0;
    hit_mod   = 1'b0;
    for (int i = 0; i < CACHE_N; i++) begin
      if (hit_vec[i]) begin
        hit       = 1'b1;
        hit_idx   = IDX_W'(i);
        hit_frame = frame_arr[i];
        hit_mod   = mod_vec[i];
      end
    end
  end

  // a write to a clean entry walks to set the flag
  assign use_hit = hit && (!cpu_in.write || hit_mod);

  // victim: first free entry, else the oldest
  always_comb begin
    vic_idx = '0;
    for (int i = CACHE_N - 1; i >= 0; i--) begin
      if (age_arr[i] == AGE_OLDEST) vic_idx = IDX_W'(i);
    end
    for (int i = CACHE_N - 1; i >= 0; i--) begin
      if (!val_vec[i]) vic_idx = IDX_W'(i);
    end
    // clean write hit refills its own entry, no duplicate tag
    if (reuse_q) vic_idx = reuse_idx_q;
  end

  // fill and recency update
  assign fill_en   = st_q == S_FILL;
  assign fill_tag  = {space_q, req_q.laddr[ADDR_W-1:OFS_W]};
  assign touch_en  = (take && use_hit) || fill_en;
  assign touch_idx = fill_en ? vic_idx : hit_idx;
  assign touch_age = age_arr[touch_idx];

  // =========================================================
  // cache entries
  for (genvar g = 0; g < CACHE_N; g++) begin : g_ent
    pat_entry #(.IDX(g)) u_ent (
      .pclk        (pclk),
      .presetn     (presetn),
      .lk_tag      (lk_tag),
      .fill_en     (fill_en && vic_idx == IDX_W'(g)),
      .fill_tag    (fill_tag),
      .fill_frame  (ent_q[ADDR_W-1:OFS_W]),
      .fill_mod    (ent_q[F_MOD]),
      .touch_en    (touch_en),
      .touch_me    (touch_idx == IDX_W'(g)),
      .touch_age   (touch_age),
      .inv_page_en (inv_page_en),
      .inv_page    (inv_page),
      .inv_sys     (inv_sys),
      .inv_usr     (inv_usr),
      .hit         (hit_vec[g]),
      .valid       (val_vec[g]),
      .frame       (frame_arr[g]),
      .mod         (mod_vec[g]),
      .age         (age_arr[g])
    );
  end

  // =========================================================
  // table addresses
  // root index picks a four-byte root entry
  assign root_addr = {(space ? usr_root[ADDR_W-1:ROOT_W+2]
                             : sys_root[ADDR_W-1:ROOT_W+2]),
                      cpu_in.laddr[ADDR_W-1:ADDR_W-ROOT_W], ENTRY_PAD};

  // pointer table sits in the frame named by the root entry
  assign ptr_addr = {mem_rdata[ADDR_W-1:OFS_W],
                     req_q.laddr[OFS_W+PTR_W-1:OFS_W], ENTRY_PAD};

  // flags the final entry must carry
  assign ptr_new = mem_rdata | REF_MASK | (req_q.write ? MOD_MASK : '0);
  assign need_ptr_wb = ptr_new != mem_rdata;

  // =========================================================
  // table walk and memory requests
  // miss walks root then pointer table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= S_IDLE;
      req_q     <= '0;
      space_q   <= 1'b0;
      root_q    <= '0;
      ent_q     <= '0;
      mem_req_q <= 1'b0;
      mem_q     <= '0;
      reuse_q     <= 1'b0;
      reuse_idx_q <= '0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (take && !use_hit) begin
            reuse_q     <= hit;
            reuse_idx_q <= hit_idx;
            req_q     <= cpu_in;
            space_q   <= space;
            mem_req_q <= 1'b1;
            mem_q     <= '{addr: root_addr, write: 1'b0, wdata: '0};
            st_q      <= S_RROOT;
          end
        end
        S_RROOT: begin
          if (mem_ack) begin
            root_q <= mem_rdata;
            if (!mem_rdata[F_VALID]) begin
              mem_req_q <= 1'b0;
              st_q      <= S_FAULT;
            end else if (!mem_rdata[F_REF]) begin
              mem_q <= '{addr: mem_q.addr, write: 1'b1,
                         wdata: mem_rdata | REF_MASK};
              st_q  <= S_WROOT;
            end else begin
              mem_q <= '{addr: ptr_addr, write: 1'b0, wdata: '0};
              st_q  <= S_RPTR;
            end
          end
        end
        S_WROOT: begin
          if (mem_ack) begin
            mem_q <= '{addr: {root_q[ADDR_W-1:OFS_W],
                              req_q.laddr[OFS_W+PTR_W-1:OFS_W],
                              ENTRY_PAD},
                       write: 1'b0, wdata: '0};
            st_q  <= S_RPTR;
          end
        end
        S_RPTR: begin
          if (mem_ack) begin
            ent_q <= ptr_new;
            if (!mem_rdata[F_VALID]) begin
              mem_req_q <= 1'b0;
              st_q      <= S_FAULT;
            // changed flags go back to memory
            end else if (need_ptr_wb) begin
              mem_q <= '{addr: mem_q.addr, write: 1'b1, wdata: ptr_new};
              st_q  <= S_WPTR;
            end else begin
              mem_req_q <= 1'b0;
              st_q      <= S_FILL;
            end
          end
        end
        S_WPTR: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            st_q      <= S_FILL;
          end
        end
        S_FILL: begin
          st_q <= S_IDLE;
        end
        S_FAULT: begin
          st_q <= S_IDLE;
        end
        default: begin
          mem_req_q <= 1'b0;
          st_q      <= S_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // cpu answers
  // hit answers on the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      paddr_q <= '0;
    end else begin
      done_q  <= (take && use_hit) || st_q == S_FILL;
      abort_q <= st_q == S_FAULT;
      if (take && use_hit) begin
        paddr_q <= {hit_frame, cpu_in.laddr[OFS_W-1:0]};
      end else if (st_q == S_FILL) begin
        paddr_q <= {ent_q[ADDR_W-1:OFS_W], req_q.laddr[OFS_W-1:0]};
      end
    end
  end

  // cpu must drop its access on abort
  assign cpu_done  = done_q;
  assign cpu_abort = abort_q;
  assign cpu_paddr = paddr_q;
  assign mem_req   = mem_req_q;
  assign mem_out   = mem_q;

endmodule : pat_translator

// file: hdl/pat_pkg.sv
// Purpose: shared constants and types of the paged address translator
// Assumes: 24-bit logical and physical addresses, 32-bit table entries
// Notes:   the APB register offsets are byte addresses
package pat_pkg;

  // =========================================================
  // address geometry
  localparam int ADDR_W   = 24;
  localparam int PAGE_W   = 15;
  localparam int OFS_W    = 9;
  localparam int ROOT_W   = 8;
  localparam int PTR_W    = 7;
  localparam int DATA_W   = 32;
  localparam int TAG_W    = PAGE_W + 1;
  localparam int CACHE_N  = 32;
  localparam int AGE_W    = 5;
  localparam int IDX_W    = 5;
  localparam logic [AGE_W-1:0] AGE_OLDEST = 5'h1F;

  // =========================================================
  // table entry fields
  localparam int F_VALID  = 0;
  localparam int F_REF    = 1;
  localparam int F_MOD    = 2;
  localparam int F_RIGHTS = 3;
  localparam logic [DATA_W-1:0] REF_MASK = 32'h0000_0002;
  localparam logic [DATA_W-1:0] MOD_MASK = 32'h0000_0004;
  localparam logic [1:0] ENTRY_PAD = 2'h0;

  // =========================================================
  // register map
  localparam logic [7:0] REG_SYS_ROOT = 8'h00;
  localparam logic [7:0] REG_USR_ROOT = 8'h04;
  localparam logic [7:0] REG_INVAL    = 8'h08;
  localparam logic [7:0] REG_STATE    = 8'h0C;
  localparam int ST_SPLIT = 0;
  localparam int ST_BUSY  = 1;
  localparam int ST_FAULT = 2;

  // =========================================================
  // carriers and states
  typedef struct packed {
    logic [ADDR_W-1:0] laddr;
    logic              write;
    logic              user;
  } pat_cpu_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [DATA_W-1:0] wdata;
  } pat_mem_req_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_RROOT = 3'h1,
    S_WROOT = 3'h3,
    S_RPTR  = 3'h2,
    S_WPTR  = 3'h6,
    S_FILL  = 3'h7,
    S_FAULT = 3'h5
  } pat_state_t;

endpackage : pat_pkg

// file: hdl/pat_entry.sv
// Purpose: one translation cache entry with its age for replacement
// Assumes: ages of all entries form a permutation of 0..31
// Notes:   tag bit 15 marks the user root space
`timescale 1ns/1ps
module pat_entry #(
  parameter int IDX = 0
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [pat_pkg::TAG_W-1:0] lk_tag,
  input  wire logic                      fill_en,
  input  wire logic [pat_pkg::TAG_W-1:0] fill_tag,
  input  wire logic [pat_pkg::PAGE_W-1:0] fill_frame,
  input  wire logic                      fill_mod,
  input  wire logic                      touch_en,
  input  wire logic                      touch_me,
  input  wire logic [pat_pkg::AGE_W-1:0] touch_age,
  input  wire logic                      inv_page_en,
  input  wire logic [pat_pkg::PAGE_W-1:0] inv_page,
  input  wire logic                      inv_sys,
  input  wire logic                      inv_usr,
  output logic                           hit,
  output logic                           valid,
  output logic [pat_pkg::PAGE_W-1:0]     frame,
  output logic                           mod,
  output logic [pat_pkg::AGE_W-1:0]      age
);
  import pat_pkg::*;

  logic [TAG_W-1:0]  tag_q;
  logic [PAGE_W-1:0] frame_q;
  logic              valid_q;
  logic              mod_q;
  logic [AGE_W-1:0]  age_q;

  // content and validity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
      tag_q   <= '0;
      frame_q <= '0;
      mod_q   <= 1'b0;
    end else if (fill_en) begin
      valid_q <= 1'b1;
      tag_q   <= fill_tag;
      frame_q <= fill_frame;
      mod_q   <= fill_mod;
    end else if (inv_page_en && tag_q[PAGE_W-1:0] == inv_page) begin
      valid_q <= 1'b0;
    end else if ((inv_sys && !tag_q[PAGE_W]) ||
                 (inv_usr && tag_q[PAGE_W])) begin
      valid_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= AGE_W'(IDX);
    end else if (touch_en) begin
      if (touch_me) begin
        age_q <= '0;
      end else if (age_q < touch_age) begin
        age_q <= age_q + 1'b1;
      end
    end
  end

  assign hit   = valid_q && (tag_q == lk_tag);
  assign valid = valid_q;
  assign frame = frame_q;
  assign mod   = mod_q;
  assign age   = age_q;

endmodule : pat_entry

// file: hdl/pat_regs.sv
// Purpose: APB register file of the translator
// Assumes: zero wait states, byte addresses, 32-bit data
// Notes:   a fault capture wins over a software write in the same cycle
`timescale 1ns/1ps
module pat_regs (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [pat_pkg::DATA_W-1:0] pwdata,
  output logic [pat_pkg::DATA_W-1:0]      prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       fault_set,
  input  wire logic [pat_pkg::ADDR_W-1:0] fault_addr,
  input  wire logic                       busy,
  output logic [pat_pkg::ADDR_W-1:0]      system_table_root_reg,
  output logic [pat_pkg::ADDR_W-1:0]      user_table_root_reg,
  output logic                            split_space_bit,
  output logic                            inv_page_en,
  output logic [pat_pkg::PAGE_W-1:0]      inv_page,
  output logic                            inv_sys,
  output logic                            inv_usr
);
  import pat_pkg::*;

  logic [ADDR_W-1:0] invalidate_address_reg;
  logic              fault_q;
  logic [DATA_W-1:0] prdata_q;
  logic              wr;
  logic              known;
  logic [DATA_W-1:0] rd_mux;

  assign wr    = psel && penable && pwrite;
  assign known = (paddr == REG_SYS_ROOT) || (paddr == REG_USR_ROOT) ||
                 (paddr == REG_INVAL) || (paddr == REG_STATE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_table_root_reg <= '0;
      user_table_root_reg   <= '0;
      split_space_bit       <= 1'b0;
    end else if (wr) begin
      if (paddr == REG_SYS_ROOT) system_table_root_reg <= pwdata[ADDR_W-1:0];
      if (paddr == REG_USR_ROOT) user_table_root_reg <= pwdata[ADDR_W-1:0];
      if (paddr == REG_STATE) split_space_bit <= pwdata[ST_SPLIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_page_en <= 1'b0;
      inv_page    <= '0;
      inv_sys     <= 1'b0;
      inv_usr     <= 1'b0;
    end else begin
      inv_page_en <= wr && paddr == REG_INVAL;
      inv_page    <= pwdata[ADDR_W-1:OFS_W];
      inv_sys     <= wr && paddr == REG_SYS_ROOT;
      inv_usr     <= wr && paddr == REG_USR_ROOT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalidate_address_reg <= '0;
      fault_q                <= 1'b0;
    end else begin
      if (fault_set) begin
        invalidate_address_reg <= fault_addr;
      end else if (wr && paddr == REG_INVAL) begin
        invalidate_address_reg <= pwdata[ADDR_W-1:0];
      end
      if (fault_set) begin
        fault_q <= 1'b1;
      end else if (wr && paddr == REG_STATE && pwdata[ST_FAULT]) begin
        fault_q <= 1'b0;
      end
    end
  end

  // read mux, sampled in the setup phase
  always_comb begin
    rd_mux = '0;
    case (paddr)
      REG_SYS_ROOT: rd_mux[ADDR_W-1:0] = system_table_root_reg;
      REG_USR_ROOT: rd_mux[ADDR_W-1:0] = user_table_root_reg;
      REG_INVAL:    rd_mux[ADDR_W-1:0] = invalidate_address_reg;
      REG_STATE: begin
        rd_mux[ST_SPLIT] = split_space_bit;
        rd_mux[ST_BUSY]  = busy;
        rd_mux[ST_FAULT] = fault_q;
      end
      default:      rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;

endmodule : pat_regs

// file: test/pat_translator_asserts.sv
// Purpose: port checks of the paged address translator
// Assumes: one clock domain, reset active low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module pat_translator_asserts (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  cpu_req,
  input wire pat_pkg::pat_cpu_req_t cpu_in,
  input wire logic                  cpu_done,
  input wire logic                  cpu_abort,
  input wire logic [23:0]           cpu_paddr,
  input wire logic                  mem_req,
  input wire pat_pkg::pat_mem_req_t mem_out,
  input wire logic                  mem_ack
);
  import pat_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // answer and walk checks
  offset_pass_a: assert property (
    cpu_done |-> cpu_paddr[8:0] == cpu_in.laddr[8:0])
    else $error("offset not passed through");
  paddr_hold_a: assert property (
    !cpu_done |-> $stable(cpu_paddr))
    else $error("physical address moved without answer");
  root_index_a: assert property (
    $rose(cpu_req) ##1 mem_req |->
      mem_out.addr[9:2] == cpu_in.laddr[23:16] && !mem_out.write)
    else $error("root entry index wrong");
  entry_align_a: assert property (
    mem_req |-> mem_out.addr[1:0] == 2'h0)
    else $error("table access not word aligned");
  wb_ref_a: assert property (
    mem_req && mem_out.write |-> mem_out.wdata[1] && mem_out.wdata[0])
    else $error("write back without referenced flag");
  mem_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_out))
    else $error("table request changed before ack");
  answer_cause_a: assert property (
    cpu_done || cpu_abort |-> $past(cpu_req))
    else $error("answer without request");
  done_pulse_a: assert property (
    cpu_done |=> !cpu_done)
    else $error("done longer than one cycle");
  abort_pulse_a: assert property (
    cpu_abort |=> !cpu_abort && !cpu_done)
    else $error("abort longer than one cycle");
  answer_excl_a: assert property (
    !(cpu_done && cpu_abort))
    else $error("done and abort together");
  cover property (cpu_done && $past(!mem_req, 2));
  cover property (cpu_abort);
  cover property (mem_req && mem_out.write && mem_ack);
endmodule : pat_translator_asserts

// file: test/pat_mem_model.sv
// Purpose: table memory answering the translator walk
// Assumes: tables live below byte address 0x1000
// Notes:   lat adds wait cycles before each ack
`timescale 1ns/1ps
module pat_mem_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  mem_req,
  input  wire pat_pkg::pat_mem_req_t mem_out,
  output logic                       mem_ack,
  output logic [31:0]                mem_rdata
);
  import pat_pkg::*;
  logic [31:0] m [0:1023];
  int          lat = 0;
  int          wait_n;
  // ==========================================
  // one access per ack, inverted data after it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'hA5A5_A5A5;
      wait_n <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_n < lat) begin
      wait_n <= wait_n + 1;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      wait_n <= 0;
      if (mem_out.write) m[mem_out.addr[11:2]] <= mem_out.wdata;
      else mem_rdata <= m[mem_out.addr[11:2]];
    end
  end
endmodule : pat_mem_model

// file: test/tb.sv
// Purpose: self-checking bench of the paged address translator
// Assumes: apb answers at once, memory model in place of ram
// Notes:   page A maps through system and user tables
`timescale 1ns/1ps
module tb;
  import pat_pkg::*;
  logic          pclk = 1'b0, presetn = 1'b0, cpu_req = 1'b0;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, prdata, mem_rdata, q;
  logic          pready, pslverr, cpu_done, cpu_abort, mem_req, mem_ack;
  pat_cpu_req_t  cpu_in = '0;
  pat_mem_req_t  mem_out;
  logic [23:0]   cpu_paddr;
  logic          err, aborted;
  int            mismatches = 0, compares = 0, cyc, walks;
  pat_translator pat_translator_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .cpu_in(cpu_in), .cpu_done(cpu_done),
    .cpu_abort(cpu_abort), .cpu_paddr(cpu_paddr), .mem_req(mem_req),
    .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  pat_mem_model pat_mem_model_inst (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .mem_out(mem_out), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // ==========================================
  // clock, shared tasks
  always #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    chk(n < 50, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xlate(input logic [23:0] la, input logic wr, us);
    cyc = 0;
    walks = 0;
    @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_in <= '{laddr: la, write: wr, user: us};
    do begin
      @(posedge pclk);
      #1;
      cyc++;
      if (mem_req === 1'b1) walks++;
    end while (cpu_done !== 1'b1 && cpu_abort !== 1'b1 && cyc < 300);
    aborted = cpu_abort;
    chk(cyc < 300, 1'b1);
    @(posedge pclk);
    cpu_req <= 1'b0;
  endtask : xlate
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // ==========================================
  // scenarios
  task automatic t_walk_hit();
    xlate(24'h010A55, 1'b0, 1'b0);
    chk({aborted, cpu_paddr}, 25'h0024655);
    chk(walks > 0, 1'b1);
    chk(pat_mem_model_inst.m[1], 32'h0000_0403);
    chk(pat_mem_model_inst.m[261], 32'h0002_4603);
    xlate(24'h010BFF, 1'b0, 1'b0);
    chk(cpu_paddr, 24'h0247FF);
    chk({cyc[15:0], walks[15:0]}, 32'h0001_0000);
  endtask : t_walk_hit
  task automatic t_write();
    xlate(24'h010A00, 1'b1, 1'b0);
    chk(pat_mem_model_inst.m[261], 32'h0002_4607);
    xlate(24'h010A01, 1'b1, 1'b0);
    chk({cyc[7:0], cpu_paddr}, 32'h0102_4601);
  endtask : t_write
  task automatic t_fault();
    xlate(24'h010C00, 1'b0, 1'b0);
    chk(aborted, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0001_0C00);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q[2], 1'b1);
    apb(1'b1, 8'h0C, 32'h4);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q[2], 1'b0);
  endtask : t_fault
  task automatic t_space();
    apb(1'b1, 8'h08, 32'h0001_0A00);
    xlate(24'h010A55, 1'b0, 1'b0);
    chk(walks > 0, 1'b1);
    pat_mem_model_inst.lat = 3;
    apb(1'b1, 8'h04, 32'h800);
    xlate(24'h010A55, 1'b0, 1'b1);
    chk(cpu_paddr, 24'h015655);
    apb(1'b1, 8'h0C, 32'h1);
    xlate(24'h010A55, 1'b0, 1'b1);
    chk(cpu_paddr, 24'h024655);
    apb(1'b1, 8'h00, 32'h800);
    xlate(24'h010A55, 1'b0, 1'b0);
    chk({walks > 0, cpu_paddr}, 25'h1015655);
    apb(1'b1, 8'h0C, 32'h0);
    xlate(24'h010A55, 1'b0, 1'b1);
    chk({walks[15:0], cpu_paddr[15:0]}, 32'h0000_5655);
    apb(1'b1, 8'h04, 32'h800);
    xlate(24'h010A55, 1'b0, 1'b1);
    chk({walks > 0, cpu_paddr}, 25'h1015655);
  endtask : t_space
  task automatic t_regs();
    apb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    chk(q, 32'h0);
  endtask : t_regs
  // ==========================================
  // tables, reset, run and watchdog
  initial begin
    pat_mem_model_inst.m[1] = 32'h0000_0401;
    pat_mem_model_inst.m[261] = 32'h0002_4601;
    pat_mem_model_inst.m[262] = 32'h0;
    pat_mem_model_inst.m[513] = 32'h0000_0601;
    pat_mem_model_inst.m[389] = 32'h0001_5601;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_walk_hit();
    t_write();
    t_fault();
    t_space();
    finish_test();
  end
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule : tb
bind pat_translator pat_translator_asserts pat_translator_asserts_inst (
  .pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .cpu_in(cpu_in),
  .cpu_done(cpu_done), .cpu_abort(cpu_abort), .cpu_paddr(cpu_paddr),
  .mem_req(mem_req), .mem_out(mem_out), .mem_ack(mem_ack));
